//--- rtl/rcg_top.sv
// reference clock generator: control word, gating, divider and output pin
// assumes source clocks arrive as tick enables and idle or sleep as levels
//
// Contract
// - the generator runs only while the enable bit 15 is set.
// - with bit 13 set the generator halts while the device idles.
// - with bit 12 set the reference clock is driven on its pin.
// - with bit 11 set the output keeps toggling during sleep.
// - bit 11 has no effect for source codes zero and one.
// - bit 9 reads one during a divider switch and self-clears after.
// - bit 8 is hardware status, one while a clock request is live.
// - while enabled a new divider waits for the switch bit.
// - bits 30 to 16 hold the fifteen-bit division value.
// - bits 31, 14, 10 and 7 to 4 ignore writes and read zero.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module rcg_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rcg_pkg::RCG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [rcg_pkg::RCG_NSRC-1:0] src_ticks,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  output logic refclk_output_pin,
  output logic refclk_output_en
);
  rcg_reg_if regs ();

  logic on_reg;
  logic idle_stop_enable_reg;
  logic oe_reg;
  logic sleep_run_enable_reg;
  logic divider_switch_request_reg;
  logic active_reg;
  logic [rcg_pkg::RCG_SEL_W-1:0] refclk_source_select_reg;
  logic [rcg_pkg::RCG_DIV_W-1:0] refclk_divider_value_reg;
  logic [rcg_pkg::RCG_DIV_W-1:0] div_applied_reg;
  logic pin_reg;
  logic pin_en_reg;
  logic [31:0] wr_bits;
  logic low_code;
  logic run;
  logic src_tick;
  logic div_level;
  logic period_end;
  logic parked;
  logic switch_done;
  logic sw_set;
  rcg_pkg::rcg_state_e state;

  rcg_apb u_apb (
    .clock(clock),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .regs(regs)
  );

  // writes only reach implemented bits
  assign wr_bits = regs.wdata & rcg_pkg::RCG_CTRL_WMASK;

  // control bits, cleared at reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      on_reg <= rcg_pkg::RCG_CTRL_RESET[rcg_pkg::RCG_ON_BIT];
      idle_stop_enable_reg <=
        rcg_pkg::RCG_CTRL_RESET[rcg_pkg::RCG_IDLE_STOP_BIT];
      oe_reg <= rcg_pkg::RCG_CTRL_RESET[rcg_pkg::RCG_OE_BIT];
      sleep_run_enable_reg <=
        rcg_pkg::RCG_CTRL_RESET[rcg_pkg::RCG_SLEEP_RUN_BIT];
    end else if (regs.wr_stb) begin
      on_reg <= wr_bits[rcg_pkg::RCG_ON_BIT];
      idle_stop_enable_reg <= wr_bits[rcg_pkg::RCG_IDLE_STOP_BIT];
      oe_reg <= wr_bits[rcg_pkg::RCG_OE_BIT];
      sleep_run_enable_reg <= wr_bits[rcg_pkg::RCG_SLEEP_RUN_BIT];
    end
  end

  // source selector and software divider field
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      refclk_source_select_reg <= rcg_pkg::RCG_CTRL_RESET[
        rcg_pkg::RCG_SEL_LSB +: rcg_pkg::RCG_SEL_W];
      refclk_divider_value_reg <= rcg_pkg::RCG_CTRL_RESET[
        rcg_pkg::RCG_DIV_LSB +: rcg_pkg::RCG_DIV_W];
    end else if (regs.wr_stb) begin
      refclk_source_select_reg <=
        wr_bits[rcg_pkg::RCG_SEL_LSB +: rcg_pkg::RCG_SEL_W];
      refclk_divider_value_reg <=
        wr_bits[rcg_pkg::RCG_DIV_LSB +: rcg_pkg::RCG_DIV_W];
    end
  end

  // switch request: a fresh set wins over the completion clear
  assign sw_set = regs.wr_stb & wr_bits[rcg_pkg::RCG_SW_BIT];
  assign switch_done = divider_switch_request_reg & (period_end | parked);
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      divider_switch_request_reg <= 1'b0;
    end else if (sw_set) begin
      divider_switch_request_reg <= 1'b1;
    end else if (switch_done) begin
      divider_switch_request_reg <= 1'b0;
    end
  end

  // divider used by the counter: follows writes while off, so the word
  // that turns the block on starts with its own divider; when on, only at
  // a period end or while parked, after a switch request
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      div_applied_reg <= '0;
    end else if (regs.wr_stb && !on_reg) begin
      div_applied_reg <=
        wr_bits[rcg_pkg::RCG_DIV_LSB +: rcg_pkg::RCG_DIV_W];
    end else if (!on_reg || switch_done) begin
      div_applied_reg <= refclk_divider_value_reg;
    end
  end

  // run gating from enable, idle and sleep
  assign low_code = (refclk_source_select_reg == rcg_pkg::RCG_SEL_LOW0) ||
                    (refclk_source_select_reg == rcg_pkg::RCG_SEL_LOW1);
  assign run = on_reg
    & ~(idle_mode & idle_stop_enable_reg)
    & ~(sleep_mode & (low_code | ~sleep_run_enable_reg));
  assign src_tick = src_ticks[refclk_source_select_reg];

  rcg_divider u_div (
    .clock(clock),
    .rst_b(rst_b),
    .run(run),
    .src_tick(src_tick),
    .div_value(div_applied_reg),
    .level(div_level),
    .period_end(period_end),
    .parked(parked)
  );

  // request status follows enable and any unfinished high phase
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= on_reg | div_level;
    end
  end

  // output pin stage
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pin_reg <= 1'b0;
      pin_en_reg <= 1'b0;
    end else begin
      pin_reg <= oe_reg & div_level;
      pin_en_reg <= oe_reg;
    end
  end
  assign refclk_output_pin = pin_reg;
  assign refclk_output_en = pin_en_reg;

  // readback of the control word, unimplemented bits zero
  always_comb begin
    regs.rdata = 32'h0000_0000;
    regs.rdata[rcg_pkg::RCG_DIV_LSB +: rcg_pkg::RCG_DIV_W] =
      refclk_divider_value_reg;
    regs.rdata[rcg_pkg::RCG_ON_BIT] = on_reg;
    regs.rdata[rcg_pkg::RCG_IDLE_STOP_BIT] = idle_stop_enable_reg;
    regs.rdata[rcg_pkg::RCG_OE_BIT] = oe_reg;
    regs.rdata[rcg_pkg::RCG_SLEEP_RUN_BIT] = sleep_run_enable_reg;
    regs.rdata[rcg_pkg::RCG_SW_BIT] = divider_switch_request_reg;
    regs.rdata[rcg_pkg::RCG_ACT_BIT] = active_reg;
    regs.rdata[rcg_pkg::RCG_SEL_LSB +: rcg_pkg::RCG_SEL_W] =
      refclk_source_select_reg;
  end

  // observed divider state for coverage
  always_comb begin
    if (parked) begin
      state = rcg_pkg::RCG_PARKED;
    end else if (run) begin
      state = rcg_pkg::RCG_RUNNING;
    end else begin
      state = rcg_pkg::RCG_DRAINING;
    end
  end

  // checks on the control behaviour
  off_quiet_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !on_reg && !div_level |=> !div_level)
    else $error("output toggled while disabled");
  run_off_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !on_reg |-> !run)
    else $error("generator ran with the enable bit clear");
  idle_stop_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    idle_mode && idle_stop_enable_reg |-> !run)
    else $error("generator ran in idle with stop set");
  idle_run_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    on_reg && !idle_stop_enable_reg && !sleep_mode |-> run)
    else $error("generator stopped in idle with stop clear");
  pin_gate_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !oe_reg ##1 1'b1 |-> !refclk_output_pin && !refclk_output_en)
    else $error("pin carried clock with output drive clear");
  pin_follow_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    oe_reg |=> refclk_output_pin == $past(div_level))
    else $error("pin did not follow divider level");
  en_follow_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    oe_reg |=> refclk_output_en)
    else $error("pin drive enable did not follow bit 12");
  sleep_run_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    sleep_mode && sleep_run_enable_reg && !low_code && on_reg &&
    !(idle_mode && idle_stop_enable_reg) |-> run)
    else $error("generator stopped in sleep with run-in-sleep set");
  sleep_stop_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    sleep_mode && !sleep_run_enable_reg |-> !run)
    else $error("generator ran in sleep with run-in-sleep clear");
  sleep_low_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    sleep_mode && low_code |-> !run)
    else $error("run-in-sleep honoured for a low source code");
  switch_set_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    sw_set |=> divider_switch_request_reg)
    else $error("switch bit not set by a write");
  switch_hold_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    divider_switch_request_reg && !switch_done |=>
      divider_switch_request_reg)
    else $error("switch bit cleared before completion");
  switch_clear_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    switch_done && !sw_set |=> !divider_switch_request_reg)
    else $error("switch bit not cleared after completion");
  active_track_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    ##1 active_reg == $past(on_reg || div_level))
    else $error("request status wrong");
  active_on_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    on_reg |=> active_reg)
    else $error("request status low while enabled");
  div_hold_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    on_reg && !divider_switch_request_reg |=> $stable(div_applied_reg))
    else $error("divider changed without a switch");
  div_switch_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    on_reg && switch_done |=>
      div_applied_reg == $past(refclk_divider_value_reg))
    else $error("divider not applied at the switch");
  div_follow_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !on_reg |=> div_applied_reg == refclk_divider_value_reg)
    else $error("divider not loaded while disabled");
  div_write_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    regs.wr_stb |=> refclk_divider_value_reg ==
      $past(wr_bits[rcg_pkg::RCG_DIV_LSB +: rcg_pkg::RCG_DIV_W]))
    else $error("divider field not taken from the write");
  unimpl_zero_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (regs.rdata & ~rcg_pkg::RCG_CTRL_RMASK) == 32'h0000_0000)
    else $error("unimplemented bits read nonzero");
  sel_write_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    regs.wr_stb |=> refclk_source_select_reg ==
      $past(wr_bits[rcg_pkg::RCG_SEL_LSB +: rcg_pkg::RCG_SEL_W]))
    else $error("source selector not taken from the write");
  reset_clear_a: assert property (
    @(posedge clock)
    !rst_b |=> regs.rdata == rcg_pkg::RCG_CTRL_RESET)
    else $error("control word not cleared by reset");
  reset_pin_a: assert property (
    @(posedge clock)
    !rst_b |=> !refclk_output_pin && !refclk_output_en)
    else $error("output pin not released by reset");

  // main scenarios
  switch_seen_c: cover property (@(posedge clock) disable iff (!rst_b)
    on_reg && switch_done && period_end);
  pin_toggle_c: cover property (@(posedge clock) disable iff (!rst_b)
    refclk_output_en && $rose(refclk_output_pin));
  drain_c: cover property (@(posedge clock) disable iff (!rst_b)
    state == rcg_pkg::RCG_DRAINING ##[1:100] state == rcg_pkg::RCG_PARKED);
  idle_hold_c: cover property (@(posedge clock) disable iff (!rst_b)
    idle_mode && on_reg && !run);
  sleep_run_c: cover property (@(posedge clock) disable iff (!rst_b)
    sleep_mode && run && refclk_output_en);
endmodule

//--- rtl/rcg_pkg.sv
// constants and types shared by the reference clock generator files
// assumes a 32-bit apb register bus and single-cycle source tick inputs
package rcg_pkg;
  // register map
  localparam int RCG_ADDR_W = 12;
  localparam logic [11:0] RCG_CTRL_OFFSET = 12'h000;
  localparam logic [31:0] RCG_CTRL_RESET = 32'h0000_0000;
  // writable and readable bits of the control word
  localparam logic [31:0] RCG_CTRL_WMASK = 32'h7fff_ba0f;
  localparam logic [31:0] RCG_CTRL_RMASK = 32'h7fff_bb0f;
  // field positions
  localparam int RCG_DIV_LSB = 16;
  localparam int RCG_DIV_W = 15;
  localparam int RCG_ON_BIT = 15;
  localparam int RCG_IDLE_STOP_BIT = 13;
  localparam int RCG_OE_BIT = 12;
  localparam int RCG_SLEEP_RUN_BIT = 11;
  localparam int RCG_SW_BIT = 9;
  localparam int RCG_ACT_BIT = 8;
  localparam int RCG_SEL_LSB = 0;
  localparam int RCG_SEL_W = 4;
  localparam int RCG_NSRC = 16;
  // source codes for which the run-in-sleep bit is ignored
  localparam logic [3:0] RCG_SEL_LOW0 = 4'h0;
  localparam logic [3:0] RCG_SEL_LOW1 = 4'h1;
  localparam logic [14:0] RCG_DIV_ONE = 15'h0001;
  localparam logic [14:0] RCG_DIV_ZERO = 15'h0000;
  // divider output states
  typedef enum logic [1:0] {RCG_PARKED, RCG_RUNNING, RCG_DRAINING} rcg_state_e;
endpackage

//--- rtl/rcg_reg_if.sv
// register access carrier between the apb slave and the generator core
// assumes both ends share the one system clock
`timescale 1ns/1ps
interface rcg_reg_if;
  logic wr_stb;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus_side (output wr_stb, output wdata, input rdata);
  modport core_side (input wr_stb, input wdata, output rdata);
endinterface

//--- rtl/rcg_apb.sv
// apb slave for the single control word of the reference clock generator
// assumes an apb master that holds its request until pready is seen
`timescale 1ns/1ps
module rcg_apb (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rcg_pkg::RCG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  rcg_reg_if.bus_side regs
);
  logic hit;
  logic [31:0] prdata_reg;

  // address decode, zero wait states
  assign hit = (paddr == rcg_pkg::RCG_CTRL_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign regs.wr_stb = psel & penable & pwrite & hit;
  assign regs.wdata = pwdata;
  assign prdata = prdata_reg;

  // read data captured in the setup cycle, zero when unmapped
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_reg <= (hit && !pwrite) ? regs.rdata : 32'h0000_0000;
    end
  end
endmodule

//--- rtl/rcg_divider.sv
// divides the selected source ticks into a square reference clock level
// assumes src_tick is a one-cycle enable pulse per source clock period
`timescale 1ns/1ps
module rcg_divider (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic run,
  input wire logic src_tick,
  input wire logic [rcg_pkg::RCG_DIV_W-1:0] div_value,
  output logic level,
  output logic period_end,
  output logic parked
);
  logic [rcg_pkg::RCG_DIV_W-1:0] cnt_reg;
  logic level_reg;
  logic wrap;
  logic step;

  // a stop request lets a high phase finish so the output never glitches
  assign step = src_tick & (run | level_reg);
  assign wrap = (div_value == rcg_pkg::RCG_DIV_ZERO) ||
                (cnt_reg == div_value - rcg_pkg::RCG_DIV_ONE);
  assign period_end = step & wrap & level_reg;
  assign parked = ~run & ~level_reg;
  assign level = level_reg;

  // half-period counter
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else if (parked) begin
      cnt_reg <= '0;
    end else if (step) begin
      cnt_reg <= wrap ? '0 : cnt_reg + rcg_pkg::RCG_DIV_ONE;
    end
  end

  // output level toggles at each half-period end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      level_reg <= 1'b0;
    end else if (step && wrap) begin
      level_reg <= ~level_reg;
    end
  end
endmodule

//--- test/rcg_tb_top.sv
// self-checking bench for the reference clock generator top module
// assumes every source ticks each cycle and one apb master drives the bus
`timescale 1ns/1ps
module reference_clock_output_generator_tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] src_ticks = 16'hffff;
  logic idle_mode = 1'b0;
  logic sleep_mode = 1'b0;
  logic refclk_output_pin;
  logic refclk_output_en;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 87;
  logic [31:0] rd;
  logic [31:0] d;
  logic err;
  int p;
  int c;
  // {toggles expected, idle, sleep, low control half}
  logic [18:0] cases [6] = '{19'h2_b002, 19'h6_9002, 19'h5_9802,
                             19'h1_9002, 19'h1_9800, 19'h1_9801};

  // free running system clock
  always #4 clock = ~clock;

  rcg_top i_dut (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_ticks(src_ticks), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
    .refclk_output_pin(refclk_output_pin),
    .refclk_output_en(refclk_output_en));

  // expected pin period in cycles when the source ticks every cycle
  function automatic int exp_period(input int n);
    return (n == 0) ? 2 : 2 * n;
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wc(input logic [31:0] wd);
    apb(1'b1, 12'h000, wd, rd, err);
  endtask

  task automatic rc();
    apb(1'b0, 12'h000, 32'h0000_0000, rd, err);
  endtask

  // cycles between two rising pin edges
  task automatic period(output int q);
    int n;
    n = 0;
    while (refclk_output_pin !== 1'b0 && n < 300) begin
      @(posedge clock);
      n++;
    end
    while (refclk_output_pin !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    q = 0;
    do begin
      @(posedge clock);
      q++;
    end while (refclk_output_pin !== 1'b0 && q < 300);
    while (refclk_output_pin !== 1'b1 && q < 300) begin
      @(posedge clock);
      q++;
    end
  endtask

  // pin changes seen over 32 cycles
  task automatic toggles(output int q);
    logic last;
    q = 0;
    last = refclk_output_pin;
    repeat (32) begin
      @(posedge clock);
      if (refclk_output_pin !== last) q++;
      last = refclk_output_pin;
    end
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #(40000 * 8);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    rc();
    check("ctrl_reset", rd, 32'h0000_0000);
    check("pin_reset", {30'h0, refclk_output_pin, refclk_output_en},
          0);
    // random words with the generator off, first one all ones except bits 15 and 9
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 32'hffff_ffff : $random(seed);
      d = d & ~32'h0000_8200;
      wc(d);
      rc();
      check("ctrl_rw", rd,
            d & rcg_pkg::RCG_CTRL_WMASK);
      check("rw_err", {31'h0, err}, 0);
      check("out_en", {31'h0, refclk_output_en}, {31'h0, d[12]});
    end
    // unmapped word is refused and leaves the control word alone
    apb(1'b1, 12'hffc, 32'hffff_ffff, rd, err);
    check("unmapped_err", {31'h0, err}, 1);
    apb(1'b0, 12'h004, 32'h0000_0000, rd, err);
    check("unmapped_rd", rd, 32'h0000_0000);
    rc();
    check("ctrl_kept", rd, d & rcg_pkg::RCG_CTRL_WMASK);
    // division ratios, enable, pin drive and status
    for (int n = 0; n < 5; n++) begin
      wc({1'b0, 15'(n), 16'h1002});
      repeat (16) @(posedge clock);
      wc({1'b0, 15'(n), 16'h9002});
      period(p);
      check("period", 32'(p), 32'(exp_period(n)));
      check("pin_en", {31'h0, refclk_output_en}, 1);
      rc();
      check("active_on", {31'h0, rd[8]}, 1);
      wc({1'b0, 15'(n), 16'h8002});
      // the pin stage lags the write by a cycle
      repeat (2) @(posedge clock);
      toggles(c);
      check("pin_undriven", 32'(c), 0);
      check("pin_en_off", {31'h0, refclk_output_en}, 0);
      wc({1'b0, 15'(n), 16'h1002});
      repeat (16) @(posedge clock);
      toggles(c);
      check("off_quiet", 32'(c), 0);
      rc();
      check("active_off", {31'h0, rd[8]}, 0);
    end
    // divider change waits for the switch request
    wc({1'b0, 15'h0002, 16'h9002});
    wc({1'b0, 15'h0005, 16'h9002});
    period(p);
    check("no_switch", 32'(p), 4);
    wc({1'b0, 15'h0005, 16'h9202});
    c = 0;
    do begin
      rc();
      c++;
    end while (rd[9] !== 1'b0 && c < 20);
    check("switch_clear", {31'h0, rd[9]}, 0);
    period(p);
    check("switched", 32'(p), 10);
    // idle and sleep gating by table, switching off with fields unchanged
    d = {1'b0, 15'h0005, 16'h9002};
    for (int i = 0; i < 6; i++) begin
      wc(d & ~32'h0000_8000);
      repeat (16) @(posedge clock);
      idle_mode <= cases[i][17];
      sleep_mode <= cases[i][16];
      d = {16'h0001, cases[i][15:0]};
      wc(d);
      repeat (16) @(posedge clock);
      toggles(c);
      check("gated", {31'h0, c > 0},
            {31'h0, cases[i][18]});
    end
    // a second reset in mid-run clears the word and the pin again
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rc();
    check("ctrl_rerun", rd, 32'h0000_0000);
    check("pin_rerun", {30'h0, refclk_output_pin, refclk_output_en},
          0);
    print_verdict();
  end
endmodule
